// file: rtl/ictim_pkg.sv
package ictim_pkg;
	// Clock and cycle shaping
	localparam int CLK_HZ = 40000000;
	localparam int PHASES_PER_CYCLE = 4;
	localparam int PHASE_W = 2;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam logic [1:0] PHASE_FIRST = 2'h0;
	// Instruction class codes presented by the decoder
	localparam int CLASS_W = 3;
	localparam logic [2:0] CLS_ORDINARY = 3'h0;
	localparam logic [2:0] CLS_JUMP = 3'h1;
	localparam logic [2:0] CLS_CALL = 3'h2;
	localparam logic [2:0] CLS_RETURN = 3'h3;
	localparam logic [2:0] CLS_IRQ_RETURN = 3'h4;
	localparam logic [2:0] CLS_TABLE_READ = 3'h5;
	localparam logic [2:0] CLS_SKIP = 3'h6;
	// Fast oscillator frequency option codes
	localparam int FREQ_W = 2;
	localparam logic [1:0] FREQ_8MHZ = 2'h0;
	localparam logic [1:0] FREQ_12MHZ = 2'h1;
	localparam logic [1:0] FREQ_16MHZ = 2'h2;
	localparam logic [1:0] FREQ_RESERVED = 2'h3;
	localparam logic [1:0] FREQ_RESET = 2'h0;
	typedef enum logic [0:0] {
		ICTIM_EXEC,
		ICTIM_EXTRA
	} ictim_state_t;
endpackage : ictim_pkg

// file: rtl/ictim_phase_ctr.sv
`timescale 1ns/1ps
`default_nettype none
module ictim_phase_ctr
	import ictim_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Phase outputs
	output logic [ictim_pkg::PHASE_W-1:0] phase_o,
	output logic last_o
);
	logic [PHASE_W-1:0] phase_reg;
	logic [PHASE_W-1:0] phase_next;
	assign phase_next = (phase_reg == PHASE_LAST) ? PHASE_FIRST :
		phase_reg + 2'h1;
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			phase_reg <= PHASE_FIRST;
		else
			phase_reg <= phase_next;
	end
	assign phase_o = phase_reg;
	assign last_o = (phase_reg == PHASE_LAST);
endmodule : ictim_phase_ctr
`default_nettype wire

// file: rtl/ictim_core.sv
// Overview of operation
// - Instruction cycle equals four system clocks
// - Ordinary instructions finish in one cycle
// - Jump, call, returns, table reads: two cycles
// - Writing program counter low adds one cycle
// - Taken skip adds a cycle, else one
// - Fast oscillator option: 8, 12, 16 MHz
`timescale 1ns/1ps
`default_nettype none
module ictim_core
	import ictim_pkg::*;
(
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_N_I,
	// Decoded instruction from the program memory side
	input wire logic INSTR_VALID_I,
	input wire logic [ictim_pkg::CLASS_W-1:0] INSTR_CLASS_I,
	input wire logic PCL_WRITE_I,
	input wire logic SKIP_TAKEN_I,
	// Oscillator configuration
	input wire logic [ictim_pkg::FREQ_W-1:0] OSC_OPTION_I,
	input wire logic FAST_OSC_FREQ_SEL_HI_I,
	input wire logic FAST_OSC_FREQ_SEL_LO_I,
	// Timing outputs
	output logic [ictim_pkg::PHASE_W-1:0] PHASE_O,
	output logic CYCLE_START_O,
	output logic FETCH_O,
	output logic RETIRE_O,
	output logic STALL_O,
	// Oscillator status
	output logic [ictim_pkg::FREQ_W-1:0] FAST_OSC_FREQ_O,
	output logic FREQ_MATCH_O
);
	ictim_state_t state_reg;
	ictim_state_t state_next;
	logic [PHASE_W-1:0] phase;
	logic phase_last;
	logic [PHASE_W-1:0] phase_out_reg;
	logic cycle_start_reg;
	logic fetch_reg;
	logic retire_reg;
	logic stall_reg;
	logic [FREQ_W-1:0] osc_freq_reg;
	logic [FREQ_W-1:0] osc_freq_next;
	logic freq_match_reg;
	logic opt_taken_reg;
	logic [PHASE_W-1:0] phase_ahead;

	// Shared phase counter keeps all timing on a four-clock grid
	ictim_phase_ctr u_phase (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.phase_o(phase),
		.last_o(phase_last)
	);

	wire cls_two_cycle;
	wire needs_extra;
	wire exec_end;
	wire extra_end;
	wire [FREQ_W-1:0] sel_bits;
	wire opt_legal;

	assign cls_two_cycle = (INSTR_CLASS_I == CLS_JUMP) ||
		(INSTR_CLASS_I == CLS_CALL) ||
		(INSTR_CLASS_I == CLS_RETURN) ||
		(INSTR_CLASS_I == CLS_IRQ_RETURN) ||
		(INSTR_CLASS_I == CLS_TABLE_READ);
	// A program counter write flushes the prefetch, so it needs a refill
	assign needs_extra = INSTR_VALID_I && (cls_two_cycle ||
		PCL_WRITE_I ||
		((INSTR_CLASS_I == CLS_SKIP) && SKIP_TAKEN_I));
	assign exec_end = phase_last && (state_reg == ICTIM_EXEC);
	assign extra_end = phase_last && (state_reg == ICTIM_EXTRA);
	// Next phase leads the counter by one clock so the registered PHASE_O stays aligned
	assign phase_ahead = (phase == PHASE_LAST) ? PHASE_FIRST :
		phase + 2'h1;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ICTIM_EXEC:
			begin
				if (exec_end && needs_extra)
					state_next = ICTIM_EXTRA;
				else
					state_next = ICTIM_EXEC;
			end
			ICTIM_EXTRA:
			begin
				// Inputs are ignored here; the refill cycle always runs out
				if (extra_end)
					state_next = ICTIM_EXEC;
			end
			default:
			begin
				state_next = ICTIM_EXEC;
			end
		endcase
	end

	// Reserved option code falls back to the slowest setting
	assign opt_legal = (OSC_OPTION_I != FREQ_RESERVED);
	assign osc_freq_next = opt_legal ? OSC_OPTION_I : FREQ_8MHZ;
	assign sel_bits = {FAST_OSC_FREQ_SEL_HI_I, FAST_OSC_FREQ_SEL_LO_I};

	// Next values of the registered outputs, all judged on the same edge
	logic [PHASE_W-1:0] phase_out_next;
	logic cycle_start_next;
	logic fetch_next;
	logic retire_next;
	logic stall_next;

	logic opt_taken_next;
	logic freq_match_next;

	assign phase_out_next = phase_ahead;
	assign cycle_start_next = phase_last;
	// A new word is fetched only when no refill cycle follows
	assign fetch_next = phase_last && (state_next == ICTIM_EXEC);
	assign retire_next = (exec_end && !needs_extra) ||
		extra_end;
	assign stall_next = (state_next == ICTIM_EXTRA);
	assign opt_taken_next = 1'b1;
	// Mismatch only costs accuracy, so it is reported, not forced
	assign freq_match_next = opt_taken_reg &&
		(sel_bits == osc_freq_reg);

	// State only moves on the last phase of an instruction cycle
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
			state_reg <= ICTIM_EXEC;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
			phase_out_reg <= PHASE_FIRST;
		else
			phase_out_reg <= phase_out_next;
	end

	// Held low through reset so no false cycle start follows it
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
			cycle_start_reg <= 1'b0;
		else
			cycle_start_reg <= cycle_start_next;
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
			fetch_reg <= 1'b0;
		else
			fetch_reg <= fetch_next;
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
			retire_reg <= 1'b0;
		else
			retire_reg <= retire_next;
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
			stall_reg <= 1'b0;
		else
			stall_reg <= stall_next;
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
			opt_taken_reg <= 1'b0;
		else
			opt_taken_reg <= opt_taken_next;
	end

	// Option is fixed once at programming time: latched after reset only
	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
			osc_freq_reg <= FREQ_RESET;
		else if (!opt_taken_reg)
			osc_freq_reg <= osc_freq_next;
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
			freq_match_reg <= 1'b0;
		else
			freq_match_reg <= freq_match_next;
	end

	// Every port comes straight from a flip-flop
	assign PHASE_O = phase_out_reg;
	assign CYCLE_START_O = cycle_start_reg;
	assign FETCH_O = fetch_reg;
	assign RETIRE_O = retire_reg;
	assign STALL_O = stall_reg;
	assign FAST_OSC_FREQ_O = osc_freq_reg;
	assign FREQ_MATCH_O = freq_match_reg;
endmodule : ictim_core
`default_nettype wire

// file: bench/ictim_pmem.sv
`timescale 1ns/1ps
`default_nettype none
module ictim_pmem (
	input wire logic clk_i, rst_n_i, fetch_i,
	input wire logic [4:0] word_i,
	output logic [5:0] inst_o
);
	// Word held for the whole instruction
	always_ff @(posedge clk_i)
		if (!rst_n_i || fetch_i)
			inst_o <= {1'h1, word_i};
endmodule : ictim_pmem
`default_nettype wire

// file: bench/ictim_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ictim_sva (
	input wire logic CLK_I, RST_N_I, PCL_WRITE_I, SKIP_TAKEN_I,
	input wire logic INSTR_VALID_I,
	input wire logic CYCLE_START_O, RETIRE_O, STALL_O,
	input wire logic [2:0] INSTR_CLASS_I,
	input wire logic [1:0] PHASE_O, FAST_OSC_FREQ_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	wire t = PHASE_O == 2'h3 && !STALL_O && INSTR_VALID_I;
	wire r = RETIRE_O && !STALL_O;
	wire [3:0] k = {INSTR_CLASS_I, PCL_WRITE_I};
	sequence x; STALL_O [*4] ##1 r; endsequence
	a_four_clk: assert property (
		CYCLE_START_O |=> !CYCLE_START_O [*3] ##1 CYCLE_START_O) else $error("period");
	a_plain_one: assert property (
		t && k == 4'h0 |=> r) else $error("plain");
	a_branch_two: assert property (
		t && k inside {[4'h2:4'hA]} && !k[0] |=> x) else $error("branch");
	a_pcl_extra: assert property (
		t && k == 4'h1 |=> x) else $error("pcl");
	a_skip_cost: assert property (
		t && k == 4'hC |-> if (SKIP_TAKEN_I) ##1 x else ##1 r) else $error("skip");
	a_freq_fixed: assert property (
		$past(RST_N_I, 2) |-> $stable(FAST_OSC_FREQ_O) && FAST_OSC_FREQ_O != 2'h3)
		else $error("freq");
	c_long: cover property (t && k == 4'h2);
	c_pcl: cover property (t && k == 4'h1);
	c_skip: cover property (t && k == 4'hC && SKIP_TAKEN_I);
endmodule : ictim_sva
bind ictim_core ictim_sva u_sva (.*);
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ictim_pkg::*;
	logic clk = 1'h0, rst_n = 1'h0, hi = 1'h0, lo = 1'h0, fet, ret, mat;
	logic [1:0] opt = FREQ_16MHZ, frq;
	logic [4:0] word = 5'h0, k;
	logic [5:0] ins;
	int n_errors = 0, tests_run = 0;
	always #12.5 clk = ~clk;
	ictim_pmem u_pm (.clk_i(clk), .rst_n_i(rst_n), .fetch_i(fet),
		.word_i(word), .inst_o(ins));
	ictim_core u_dut (.CLK_I(clk), .RST_N_I(rst_n), .INSTR_VALID_I(ins[5]),
		.INSTR_CLASS_I(ins[4:2]), .PCL_WRITE_I(ins[1]), .SKIP_TAKEN_I(ins[0]),
		.OSC_OPTION_I(opt), .FAST_OSC_FREQ_SEL_HI_I(hi),
		.FAST_OSC_FREQ_SEL_LO_I(lo), .PHASE_O(), .CYCLE_START_O(),
		.FETCH_O(fet), .RETIRE_O(ret), .STALL_O(), .FAST_OSC_FREQ_O(frq),
		.FREQ_MATCH_O(mat));
	task chk(input string s, input logic [4:0] got, exp);
		tests_run++;
		n_errors += got !== exp;
		if (got !== exp)
			$display("wrong value %s exp %0h got %0h", s, exp, got);
	endtask : chk
	// Clocks from a fetch to the retire after it
	task run(input logic [4:0] w, n);
		@(posedge clk) word <= w;
		for (k = 0; k == 0 || fet !== 1'h1 && k < 20; k++) @(negedge clk);
		for (k = 0; k == 0 || ret !== 1'h1 && k < 20; k++) @(negedge clk);
		chk("clocks", k, n);
	endtask : run
	task t_classes;
		for (int c = 0; c < 7; c++)
			run({c[2:0], 2'h0}, 5'h4 << (c % 6 > 0));
		run(5'h02, 5'h8);
		run(5'h19, 5'h8);
	endtask : t_classes
	task t_osc;
		chk("match", mat, 1'h0);
		@(posedge clk) {opt, hi} <= {FREQ_8MHZ, 1'h1};
		repeat (3) @(negedge clk);
		chk("freq", frq, FREQ_16MHZ);
		chk("match", mat, 1'h1);
		// Reserved option code must fall back to the slowest setting
		@(posedge clk) {rst_n, opt} <= {1'h0, FREQ_RESERVED};
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		repeat (3) @(negedge clk);
		chk("freq", frq, FREQ_8MHZ);
		chk("match", mat, 1'h0);
	endtask : t_osc
	task finish_test(input int late);
		n_errors += late;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test
	initial #50000 finish_test(1);
	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		t_classes;
		t_osc;
		finish_test(0);
	end
endmodule : tb
`default_nettype wire
